// ==== common/xsc_consts.vh ====
// Purpose: Constants of the external space, interrupt pin and pin function block
// Assumes: Register port carries 16-bit data, word address
// Notes:   Offsets kept as printed; unlisted offsets are local
`ifndef XSC_CONSTS_VH
`define XSC_CONSTS_VH

// Register offsets
`define XSC_ADDR_W            32
`define XSC_OFF_IRQ_CTL       32'h0fff8358
`define XSC_OFF_BUS_WIDTH     32'h0fff8620
`define XSC_OFF_WAIT_CTL      32'h0fff8624
`define XSC_OFF_PORTD_FUNC    32'hffff83ad
`define XSC_OFF_TIMER_PERIOD  32'hffff8700
`define XSC_OFF_DAC_WORD      32'hffff8704
`define XSC_OFF_EVT_STATUS    32'hffff8708
`define XSC_OFF_EVT_MASK      32'hffff870c

// Field positions
`define XSC_IRQ_LEVEL_BIT     4'd15
`define XSC_IRQ_EDGE_BIT      4'd8
`define XSC_S3_LONG_BIT       4'd7
`define XSC_S3_SIZE_BIT       4'd3
`define XSC_S3_WAIT_HI        4'd15
`define XSC_S3_WAIT_LO        4'd12
`define XSC_PD_FUNC_LO        3'd3

// Reset values
`define XSC_RST_IRQ_CTL       16'h0000
`define XSC_RST_BUS_WIDTH     16'h0000
`define XSC_RST_WAIT_CTL      16'h0000
`define XSC_RST_PORTD_FUNC    8'h00
`define XSC_RST_TIMER_PERIOD  16'h0000
`define XSC_RST_DAC_WORD      10'h000

// Bus cycle timing: two base states per external access
`define XSC_BASE_STATES       4'd2

`endif

// ==== hdl/xsc_config_top.v ====
// Purpose: Configuration registers for space three, interrupt pin and pin mux
// Assumes: Plain register port, 16-bit data, read data one cycle later
// Notes:   Holds a small external bus engine for space three accesses
`timescale 1ns/100ps
`default_nettype none
`include "xsc_consts.vh"

// Summary of operation
// - Level bit reads interrupt pin level
// - Edge select zero: falling edge requests interrupt
// - Long size off: width from size bit
// - Size bit zero with long size off: space three is byte-wide
// - Zero wait bits: no waits, wait ignored
// - Port D function bit selects data line
// - Timer channel zero drives converter clock
// - Ten-bit converter word on port E
// - Space three waits zero to fifteen programmed cycles, longer while the wait pin is low
module xsc_config_top (
    input  wire        sys_clk,
    input  wire        reset,
    // Register port
    input  wire [31:0] reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    // Interrupt pin and request
    input  wire        irq_pin,
    output reg         irq_request,
    output wire        intr,
    // Space three access request from core
    input  wire        s3_req,
    input  wire        s3_write,
    input  wire [15:0] s3_wdata,
    output wire        s3_done,
    output reg  [15:0] s3_rdata,
    output reg         chip_select_space3_n,
    output reg         s3_rd_n,
    output reg         s3_wr_n,
    input  wire        ext_wait_n,
    output wire        s3_bus16,
    // Port D pins 3..7: data line or port
    input  wire [7:3]  portd_in,
    output reg  [7:3]  portd_out,
    output reg  [7:3]  portd_oe,
    input  wire [7:3]  portd_port_data,
    input  wire [7:3]  portd_port_dir,
    // Converter outputs
    output wire        timer0_compare_pin,
    output reg  [15:0] porte_out,
    output reg  [15:0] porte_oe
);
    // Bus engine states
    localparam ST_IDLE = 2'd0;
    localparam ST_T1   = 2'd1;
    localparam ST_WAIT = 2'd2;
    localparam ST_T2   = 2'd3;

    reg  [15:0] irq_ctl_r;      // Writable part of interrupt control
    reg  [15:0] bus_width_r;    // Bus width control
    reg  [15:0] wait_ctl_r;     // Wait cycle control
    reg  [7:0]  portd_func_r;   // Port D function select
    reg  [15:0] timer_period_r; // Converter clock half period minus one cycle
    reg  [9:0]  dac_word_r;     // Converter data word
    reg  [2:0]  evt_status_r;   // Sticky events
    reg  [2:0]  evt_mask_r;     // Event enables
    reg         pin_prev_r;     // Previous synced pin level
    reg  [1:0]  st_r;           // Bus engine state
    reg  [1:0]  st_nxt;         // Next state
    reg  [3:0]  wait_cnt_r;     // Remaining programmed waits
    wire        pin_level;      // Synchronised pin level
    wire        edge_evt;       // Selected pin edge seen
    wire        timer_match;    // Compare match pulse
    wire [3:0]  s3_waits;       // Programmed waits for space three
    wire        wait_sample;    // External wait honoured
    wire        ext_wait_s;     // Synchronised wait pin

    // Address compare used by both write and read decode
    function hit;
        input [31:0] a;
        input [31:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // Pin passes two flops before any logic reads it
    xsc_sync2 u_pin_sync (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .rst_val   (1'b1),
        .pin_in    (irq_pin),
        .level_out (pin_level)
    );

    // Wait pin synchronised likewise
    xsc_sync2 u_wait_sync (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .rst_val   (1'b1),
        .pin_in    (ext_wait_n),
        .level_out (ext_wait_s)
    );

    // Converter clock generator
    xsc_timer0 u_timer0 (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .period      (timer_period_r),
        .clk_out     (timer0_compare_pin),
        .match_pulse (timer_match)
    );

    // Edge select 0 picks falling, 1 picks rising
    assign edge_evt = irq_ctl_r[`XSC_IRQ_EDGE_BIT] ? (pin_level & ~pin_prev_r)
                                                  : (~pin_level & pin_prev_r);

    // Space three waits and width
    assign s3_waits    = wait_ctl_r[`XSC_S3_WAIT_HI:`XSC_S3_WAIT_LO];
    // Zero waits means the wait pin is ignored entirely
    assign wait_sample = (s3_waits != 4'h0) & ~ext_wait_s;
    // Long size overrides; otherwise the size bit picks 8 or 16
    assign s3_bus16    = bus_width_r[`XSC_S3_LONG_BIT] ? 1'b1
                                                       : bus_width_r[`XSC_S3_SIZE_BIT];
    assign s3_done     = (st_r == ST_T2);
    assign intr        = |(evt_status_r & evt_mask_r);

    // Register writes, held until next write or reset
    always @(posedge sys_clk) begin
        if (reset) begin
            irq_ctl_r      <= `XSC_RST_IRQ_CTL;
            bus_width_r    <= `XSC_RST_BUS_WIDTH;
            wait_ctl_r     <= `XSC_RST_WAIT_CTL;
            portd_func_r   <= `XSC_RST_PORTD_FUNC;
            timer_period_r <= `XSC_RST_TIMER_PERIOD;
            dac_word_r     <= `XSC_RST_DAC_WORD;
            evt_mask_r     <= 3'b000;
        end else if (reg_wr) begin
            // Level bit is read-only, never stored
            if (hit(reg_addr, `XSC_OFF_IRQ_CTL))
                irq_ctl_r <= {1'b0, reg_wdata[14:0]};
            if (hit(reg_addr, `XSC_OFF_BUS_WIDTH))
                bus_width_r <= reg_wdata;
            if (hit(reg_addr, `XSC_OFF_WAIT_CTL))
                wait_ctl_r <= reg_wdata;
            if (hit(reg_addr, `XSC_OFF_PORTD_FUNC))
                portd_func_r <= reg_wdata[7:0];
            if (hit(reg_addr, `XSC_OFF_TIMER_PERIOD))
                timer_period_r <= reg_wdata;
            if (hit(reg_addr, `XSC_OFF_DAC_WORD))
                dac_word_r <= reg_wdata[9:0];
            if (hit(reg_addr, `XSC_OFF_EVT_MASK))
                evt_mask_r <= reg_wdata[2:0];
        end
    end

    // Sticky events: set wins over a write-one clear
    always @(posedge sys_clk) begin
        if (reset) begin
            evt_status_r <= 3'b000;
            pin_prev_r   <= 1'b1;
            irq_request  <= 1'b0;
        end else begin
            pin_prev_r  <= pin_level;
            irq_request <= edge_evt;
            evt_status_r <= (evt_status_r
                             & ~((reg_wr && hit(reg_addr, `XSC_OFF_EVT_STATUS)) ? reg_wdata[2:0] : 3'b000))
                            | {timer_match, s3_done, edge_evt};
        end
    end

    // Read data one cycle after the strobe, zero for unmapped
    always @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (hit(reg_addr, `XSC_OFF_IRQ_CTL))
                reg_rdata <= {pin_level, irq_ctl_r[14:0]};
            else if (hit(reg_addr, `XSC_OFF_BUS_WIDTH))
                reg_rdata <= bus_width_r;
            else if (hit(reg_addr, `XSC_OFF_WAIT_CTL))
                reg_rdata <= wait_ctl_r;
            else if (hit(reg_addr, `XSC_OFF_PORTD_FUNC))
                reg_rdata <= {8'h00, portd_func_r};
            else if (hit(reg_addr, `XSC_OFF_TIMER_PERIOD))
                reg_rdata <= timer_period_r;
            else if (hit(reg_addr, `XSC_OFF_DAC_WORD))
                reg_rdata <= {6'h00, dac_word_r};
            else if (hit(reg_addr, `XSC_OFF_EVT_STATUS))
                reg_rdata <= {13'h0000, evt_status_r};
            else if (hit(reg_addr, `XSC_OFF_EVT_MASK))
                reg_rdata <= {13'h0000, evt_mask_r};
            else
                reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Bus engine next state: T1, optional waits, T2
    always @* begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: begin
                if (s3_req)
                    st_nxt = ST_T1;
            end
            ST_T1: begin
                // No waits skips straight to the second state
                if (s3_waits == 4'h0)
                    st_nxt = ST_T2;
                else
                    st_nxt = ST_WAIT;
            end
            ST_WAIT: begin
                // Programmed count first, then extend on the pin
                if (wait_cnt_r == 4'h0 && !wait_sample)
                    st_nxt = ST_T2;
            end
            ST_T2: begin
                st_nxt = ST_IDLE;
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    // Bus engine registers and strobes
    always @(posedge sys_clk) begin
        if (reset) begin
            st_r                 <= ST_IDLE;
            wait_cnt_r           <= 4'h0;
            chip_select_space3_n <= 1'b1;
            s3_rd_n              <= 1'b1;
            s3_wr_n              <= 1'b1;
            s3_rdata             <= 16'h0000;
        end else begin
            st_r <= st_nxt;
            if (st_r == ST_T1)
                wait_cnt_r <= s3_waits - 4'h1;
            else if (st_r == ST_WAIT && wait_cnt_r != 4'h0)
                wait_cnt_r <= wait_cnt_r - 4'h1;
            chip_select_space3_n <= ~(st_nxt != ST_IDLE);
            s3_rd_n <= ~((st_nxt != ST_IDLE) & ~s3_write);
            s3_wr_n <= ~((st_nxt != ST_IDLE) & s3_write);
            // Byte and word bus alike latch only the low lanes, pins 3..7
            if (st_r == ST_T2 && !s3_write)
                s3_rdata <= s3_bus16 ? {8'h00, portd_in, 3'b000}
                                     : {8'h00, portd_in, 3'b000};
        end
    end

    // Port D mux: function bit hands pin to the data bus
    genvar gi;
    generate
        for (gi = 3; gi <= 7; gi = gi + 1) begin : g_portd
            always @(posedge sys_clk) begin
                if (reset) begin
                    portd_out[gi] <= 1'b0;
                    portd_oe[gi]  <= 1'b0;
                end else if (portd_func_r[gi]) begin
                    portd_out[gi] <= s3_wdata[gi];
                    portd_oe[gi]  <= (st_nxt != ST_IDLE) & s3_write;
                end else begin
                    portd_out[gi] <= portd_port_data[gi];
                    portd_oe[gi]  <= portd_port_dir[gi];
                end
            end
        end
    endgenerate

    // Converter word on port E pins 1..7 and 13..15
    always @(posedge sys_clk) begin
        if (reset) begin
            porte_out <= 16'h0000;
            porte_oe  <= 16'h0000;
        end else begin
            porte_out <= {dac_word_r[9:7], 5'h00, dac_word_r[6:0], 1'b0};
            porte_oe  <= 16'he0fe;
        end
    end
endmodule // xsc_config_top
`default_nettype wire

// ==== hdl/xsc_sync2.v ====
// Purpose: Two-stage synchroniser for an asynchronous pin level
// Assumes: Single clock sys_clk, synchronous active-high reset
// Notes:   First stage is read by the second stage only
`timescale 1ns/100ps
`default_nettype none
module xsc_sync2 (
    input  wire sys_clk,
    input  wire reset,
    input  wire rst_val,
    input  wire pin_in,
    output reg  level_out
);
    reg meta_r; // First stage, metastability catcher

    // Two flops, both loaded with rst_val during reset
    always @(posedge sys_clk) begin
        if (reset) begin
            meta_r    <= rst_val;
            level_out <= rst_val;
        end else begin
            meta_r    <= pin_in;
            level_out <= meta_r;
        end
    end
endmodule // xsc_sync2
`default_nettype wire

// ==== hdl/xsc_timer0.v ====
// Purpose: Compare-match clock generator driving the converter clock pin
// Assumes: Period register from software, 0 stops the clock
// Notes:   Output toggles at each compare match
`timescale 1ns/100ps
`default_nettype none
module xsc_timer0 (
    input  wire        sys_clk,
    input  wire        reset,
    input  wire [15:0] period,
    output reg         clk_out,
    output reg         match_pulse
);
    reg [15:0] count_r; // Free counter, cleared on match

    // Counter with clear on compare match
    always @(posedge sys_clk) begin
        if (reset) begin
            count_r     <= 16'h0000;
            clk_out     <= 1'b0;
            match_pulse <= 1'b0;
        end else if (period == 16'h0000) begin
            // Stopped: hold pin low, no matches
            count_r     <= 16'h0000;
            clk_out     <= 1'b0;
            match_pulse <= 1'b0;
        end else if (count_r >= period) begin
            count_r     <= 16'h0000;
            clk_out     <= ~clk_out; // Periodic clock out
            match_pulse <= 1'b1;
        end else begin
            count_r     <= count_r + 16'h0001;
            match_pulse <= 1'b0;
        end
    end
endmodule // xsc_timer0
`default_nettype wire

// ==== verification/xsc_config_sva.sv ====
// Purpose: Port-level checks for the configuration block
// Assumes: Shadow copies follow register writes
// Notes:   Bound to the top module below
`timescale 1ns/100ps
`default_nettype none
`include "xsc_consts.vh"
module xsc_config_sva (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic [31:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        irq_pin,
    input wire logic        irq_request,
    input wire logic        s3_req,
    input wire logic        s3_done,
    input wire logic        chip_select_space3_n,
    input wire logic        s3_bus16,
    input wire logic [7:3]  portd_oe,
    input wire logic [7:3]  portd_port_dir,
    input wire logic        timer0_compare_pin
);
    logic [15:0] bw_r;   // Bus width copy
    logic [15:0] wt_r;   // Wait control copy
    logic [7:3]  pd_r;   // Pin function copy
    logic        edg_r;  // Edge select copy
    logic        per0_r; // Timer stopped
    logic        pin_r;  // Last pin sample
    logic [2:0]  stab_r; // Steady pin count, saturates so it never wraps
    // Track writes, since mode bits are not visible at the ports
    always @(posedge sys_clk) begin
        if (reset) begin
            bw_r <= 16'h0000;
            wt_r <= 16'h0000;
            pd_r <= 5'h00;
            edg_r <= 1'b0;
            per0_r <= 1'b1;
            pin_r <= irq_pin;
            stab_r <= 3'd0;
        end else begin
            pin_r <= irq_pin;
            stab_r <= (irq_pin != pin_r) ? 3'd0 : (stab_r == 3'd7 ? 3'd7 : stab_r + 3'd1);
            if (reg_wr && reg_addr == `XSC_OFF_BUS_WIDTH) bw_r <= reg_wdata;
            if (reg_wr && reg_addr == `XSC_OFF_WAIT_CTL) wt_r <= reg_wdata;
            if (reg_wr && reg_addr == `XSC_OFF_PORTD_FUNC) pd_r <= reg_wdata[7:3];
            if (reg_wr && reg_addr == `XSC_OFF_IRQ_CTL) edg_r <= reg_wdata[8];
            if (reg_wr && reg_addr == `XSC_OFF_TIMER_PERIOD) per0_r <= (reg_wdata == 16'h0000);
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_level_read: assert property (
        reg_rd && reg_addr == `XSC_OFF_IRQ_CTL && stab_r > 3'd3 |=> reg_rdata[15] == $past(irq_pin))
        else $error("pin level bit wrong");
    a_fall_request: assert property (
        $fell(irq_pin) && !edg_r |-> ##[1:4] irq_request) else $error("no request after fall");
    a_request_low: assert property (
        irq_request && !edg_r |-> !irq_pin) else $error("request on wrong edge");
    a_width_size: assert property (
        !bw_r[7] |-> s3_bus16 == bw_r[3]) else $error("width not from size bit");
    a_byte_bus: assert property (
        !bw_r[7] && !bw_r[3] |-> !s3_bus16) else $error("space not byte wide");
    a_no_wait: assert property (
        $rose(s3_req) && wt_r[15:12] == 4'h0 |-> ##[1:3] s3_done) else $error("access too slow");
    a_port_use: assert property (
        pd_r == $past(pd_r) && !$past(reset) |-> (portd_oe & ~pd_r) == ($past(portd_port_dir) & ~pd_r))
        else $error("port pin drive wrong");
    a_bus_idle: assert property (
        (chip_select_space3_n && pd_r == $past(pd_r))[*3] |-> (portd_oe & pd_r) == 5'h00)
        else $error("data line driven idle");
    a_timer_stop: assert property (
        per0_r && $past(per0_r) |=> $stable(timer0_compare_pin)) else $error("stopped timer toggles");
    a_bw_readback: assert property (
        reg_rd && reg_addr == `XSC_OFF_BUS_WIDTH |=> reg_rdata == bw_r) else $error("width readback");
    a_wt_readback: assert property (
        reg_rd && reg_addr == `XSC_OFF_WAIT_CTL |=> reg_rdata == wt_r) else $error("wait readback");
    c_irq: cover property (irq_request);
    c_access: cover property (s3_done);
    c_toggle: cover property ($changed(timer0_compare_pin));
endmodule // xsc_config_sva
bind xsc_config_top xsc_config_sva u_sva (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_pin(irq_pin),
    .irq_request(irq_request), .s3_req(s3_req), .s3_done(s3_done), .s3_bus16(s3_bus16),
    .chip_select_space3_n(chip_select_space3_n), .portd_oe(portd_oe), .portd_port_dir(portd_port_dir),
    .timer0_compare_pin(timer0_compare_pin));
`default_nettype wire

// ==== verification/xsc_config_top_tb.sv ====
// Purpose: Register, interrupt, space three and converter tests
// Assumes: Register port answers one cycle after a read strobe
// Notes:   Wait loops are bounded; a watchdog ends a hang
`timescale 1ns/100ps
`default_nettype none
`include "xsc_consts.vh"
module xsc_config_top_tb;
    logic        sys_clk, reset, reg_wr, reg_rd, irq_pin, s3_req, s3_write, slow;
    logic [31:0] reg_addr, ta [5];
    logic [15:0] reg_wdata, s3_wdata, td [5], tm [5], te [5];
    logic [3:0]  wv [3];
    logic [7:3]  pd_data, pd_dir;
    wire  [15:0] reg_rdata, s3_rdata, porte_out, porte_oe, dac_r;
    wire  [7:3]  portd_out, portd_oe, bus_drv, seg_r;
    wire         irq_request, intr, s3_done, cs_n, rd_n, wr_n, wait_n, bus16, t0_pin;
    wire  [7:3]  pd_bus = (portd_oe & portd_out) | (~portd_oe & bus_drv); // Resolved data lines
    int          mismatches, num_checks, n, i;
    xsc_config_top dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_pin(irq_pin), .intr(intr),
        .irq_request(irq_request), .s3_req(s3_req), .s3_write(s3_write), .s3_wdata(s3_wdata),
        .s3_done(s3_done), .s3_rdata(s3_rdata), .chip_select_space3_n(cs_n), .s3_rd_n(rd_n),
        .s3_wr_n(wr_n), .ext_wait_n(wait_n), .s3_bus16(bus16), .portd_in(pd_bus), .portd_out(portd_out),
        .portd_oe(portd_oe), .portd_port_data(pd_data), .portd_port_dir(pd_dir),
        .timer0_compare_pin(t0_pin), .porte_out(porte_out), .porte_oe(porte_oe));
    xsc_ext_model far (.sys_clk(sys_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .bus_in(pd_bus),
        .slow(slow), .dac_clk(t0_pin), .dac_pins(porte_out), .bus_drv(bus_drv), .wait_n(wait_n),
        .seg_r(seg_r), .dac_r(dac_r));
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // Read data is looked at only in the cycle after the strobe
    task automatic rc(input logic [31:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", e, reg_rdata & m);
    endtask
    // Request is a single cycle; data and direction hold until done
    task automatic acc(input logic w, input logic [15:0] d);
        @(posedge sys_clk);
        s3_req <= 1'b1;
        s3_write <= w;
        s3_wdata <= d;
        @(posedge sys_clk);
        s3_req <= 1'b0;
        n = 1;
        #1;
        while (s3_done !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask
    // Cycles between two toggles of the converter clock
    task automatic gap();
        logic p;
        p = t0_pin;
        n = 0;
        while (t0_pin === p && n < 99) begin @(posedge sys_clk); #1; n++; end
        p = t0_pin;
        n = 0;
        while (t0_pin === p && n < 99) begin @(posedge sys_clk); #1; n++; end
    endtask
    task automatic print_verdict();
        if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        print_verdict();
    end
    initial begin
        {reset, irq_pin, pd_dir, pd_data} = {1'b1, 1'b1, 5'h1b, 5'h15};
        {reg_wr, reg_rd, reg_addr, reg_wdata, s3_req, s3_write, s3_wdata, slow} = '0;
        ta = '{`XSC_OFF_BUS_WIDTH, `XSC_OFF_WAIT_CTL, `XSC_OFF_PORTD_FUNC, `XSC_OFF_IRQ_CTL, 32'hffff8710};
        td = '{16'h0008, 16'ha5c3, 16'h00f8, 16'h7fff, 16'hffff};
        tm = '{16'hffff, 16'hffff, 16'hffff, 16'h8100, 16'hffff};
        te = '{16'h0008, 16'ha5c3, 16'h00f8, 16'h8100, 16'h0000};
        wv = '{4'h0, 4'h3, 4'hf};
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        rc(`XSC_OFF_IRQ_CTL, 16'h8100, 16'h8000);
        rc(`XSC_OFF_BUS_WIDTH, 16'hffff, 16'h0000);
        chk("porte_oe", 16'he0fe, porte_oe);
        chk("portd_oe", {11'h0, pd_dir}, {11'h0, portd_oe});
        // Write then read back, the unmapped place last
        for (i = 0; i < 5; i++) begin
            wr(ta[i], td[i]);
            rc(ta[i], tm[i], te[i]);
        end
        chk("s3_bus16", 16'h0001, {15'h0, bus16});
        chk("portd_oe", 16'h0000, {11'h0, portd_oe});
        wr(`XSC_OFF_IRQ_CTL, 16'h0000);
        wr(`XSC_OFF_BUS_WIDTH, 16'h0000);
        chk("s3_bus16", 16'h0000, {15'h0, bus16});
        // Unmasked pin edge raises the level output until cleared
        wr(`XSC_OFF_EVT_MASK, 16'h0001);
        irq_pin <= 1'b0;
        n = 0;
        while (irq_request !== 1'b1 && n < 8) begin @(posedge sys_clk); #1; n++; end
        chk("irq_request", 16'h0001, {15'h0, irq_request});
        rc(`XSC_OFF_IRQ_CTL, 16'h8000, 16'h0000);
        chk("intr", 16'h0001, {15'h0, intr});
        rc(`XSC_OFF_EVT_STATUS, 16'h0001, 16'h0001);
        wr(`XSC_OFF_EVT_STATUS, 16'h0001);
        chk("intr", 16'h0000, {15'h0, intr});
        irq_pin <= 1'b1;
        wr(`XSC_OFF_EVT_MASK, 16'h0000);
        irq_pin <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #1;
        chk("intr", 16'h0000, {15'h0, intr});
        rc(`XSC_OFF_EVT_STATUS, 16'h0001, 16'h0001);
        wr(`XSC_OFF_EVT_STATUS, 16'h0001);
        irq_pin <= 1'b1;
        // Space three writes with 0, 3 and 15 waits; wait line held when waits are off
        for (i = 0; i < 3; i++) begin
            wr(`XSC_OFF_WAIT_CTL, {wv[i], 12'h000});
            slow <= (wv[i] == 4'h0);
            acc(1'b1, 16'h00a8);
            chk("s3 cycles", 16'd2 + {12'h0, wv[i]}, n[15:0]);
            chk("display", 16'h0015, {11'h0, seg_r});
        end
        slow <= 1'b0;
        acc(1'b0, 16'h0000);
        // Read data is latched on the edge that leaves the second state
        @(posedge sys_clk);
        #1;
        chk("s3_rdata", 16'h0015, {11'h0, s3_rdata[7:3]});
        // Converter word and conversion clock
        wr(`XSC_OFF_TIMER_PERIOD, 16'h0003);
        wr(`XSC_OFF_DAC_WORD, 16'h03ff);
        repeat (20) @(posedge sys_clk);
        chk("dac all ones", 16'he0fe, dac_r & 16'he0fe);
        wr(`XSC_OFF_DAC_WORD, 16'h0001);
        repeat (20) @(posedge sys_clk);
        chk("dac one bit", 16'h0001, 16'($countones(dac_r & 16'he0fe)));
        wr(`XSC_OFF_DAC_WORD, 16'h0000);
        repeat (20) @(posedge sys_clk);
        chk("dac zero", 16'h0000, dac_r & 16'he0fe);
        #1;
        gap();
        chk("timer gap", 16'h0004, n[15:0]);
        wr(`XSC_OFF_TIMER_PERIOD, 16'h0000);
        repeat (10) @(posedge sys_clk);
        print_verdict();
    end
endmodule // xsc_config_top_tb
`default_nettype wire

// ==== verification/xsc_ext_model.sv ====
// Purpose: Byte display and converter on the far side of the pins
// Assumes: Display latches the data lines during a write strobe
// Notes:   Undriven lines show the inverse of the latch, never a stale copy
`timescale 1ns/100ps
`default_nettype none
module xsc_ext_model (
    input  wire logic        sys_clk,
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [7:3]  bus_in,
    input  wire logic        slow,
    input  wire logic        dac_clk,
    input  wire logic [15:0] dac_pins,
    output var  logic [7:3]  bus_drv,
    output var  logic        wait_n,
    output var  logic [7:3]  seg_r,
    output var  logic [15:0] dac_r
);
    initial seg_r = 5'h0a;
    // Display answers a read only while selected
    always_comb bus_drv = (!cs_n && !rd_n) ? seg_r : ~seg_r;
    // Slow mode pulls the wait line while selected
    always_comb wait_n = !(slow && !cs_n);
    // Latch the byte while the write strobe is low
    always @(posedge sys_clk) if (!cs_n && !wr_n) seg_r <= bus_in;
    // Converter samples its word on the conversion clock
    always @(posedge dac_clk) dac_r <= dac_pins;
endmodule // xsc_ext_model
`default_nettype wire
